// File: src/clock_chip_link_controller.sv
// register file and serial sequencer for the external clock chip link
`timescale 1ns/1ps
`default_nettype none
module clock_chip_link_controller (
    // clock and reset
    input  wire logic                                I_CORE_CLK,
    input  wire logic                                I_RST_N,
    // register port
    input  wire logic [clock_chip_link_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [clock_chip_link_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic                                I_WR_STB,
    input  wire logic                                I_RD_STB,
    output logic      [clock_chip_link_pkg::DATA_W-1:0] O_RDATA,
    // serial link
    output logic                                     O_SERIAL_CLOCK_OUT,
    output logic                                     O_SERIAL_DATA_OUT,
    output logic                                     O_SERIAL_DATA_OE,
    input  wire logic                                I_SERIAL_DATA_IN,
    // chip reset pin
    output logic                                     O_CHIP_RESET_PIN_N
);
    import clock_chip_link_pkg::*;

    // address match used by every decode line
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction

    // software visible state
    logic [DIVISOR_W-1:0] divisor_ff;        // serial clock divisor
    logic [DATA_W-1:0]    outgoing_word_ff;  // data byte high, target low
    logic [7:0]           fetch_target_ff;   // target sent on reads
    logic [7:0]           incoming_byte_ff;  // last byte received
    logic                 chip_reset_level_ff; // level for the reset pin
    logic                 write_busy_ff;     // write frame in progress
    logic                 read_busy_ff;      // read frame in progress
    logic [DATA_W-1:0]    rdata_ff;          // read answer, one cycle late

    // sequencer state
    link_state_t          state_ff;          // idle or shifting
    link_state_t          nxt_state;
    logic [DATA_W-1:0]    tx_shift_ff;       // transmit shift register
    logic [DATA_W-1:0]    nxt_tx_shift;
    logic [7:0]           rx_shift_ff;       // receive shift register
    logic [7:0]           nxt_rx_shift;
    logic [3:0]           bit_idx_ff;        // bit now on the wire
    logic [3:0]           nxt_bit_idx;
    logic                 sclk_ff;           // serial clock level
    logic                 nxt_sclk;
    logic                 sdo_ff;            // data pin output level
    logic                 nxt_sdo;
    logic                 sdo_oe_ff;         // data pin drive enable
    logic                 nxt_sdo_oe;
    logic                 frame_done;        // last falling tick of a frame
    logic                 pin_reset_n_ff;    // registered copy for the pin

    // input synchroniser for the data pin
    logic                 sdi_s1_ff;         // first stage, read by stage two only
    logic                 sdi_s2_ff;
    logic                 sdi_s3_ff;
    logic                 sdi_filt_ff;       // accepted pin level

    // divider pacing
    logic                 half_tick;         // end of a serial clock half period

    // bus decode
    wire                  wr_ctrl   = I_WR_STB && hit(I_ADDR, TRANSFER_CONTROL_ADDR);
    wire                  wr_div    = I_WR_STB && hit(I_ADDR, SERIAL_CLOCK_DIVISOR_ADDR);
    wire                  wr_out    = I_WR_STB && hit(I_ADDR, OUTGOING_WORD_ADDR);
    wire                  wr_in     = I_WR_STB && hit(I_ADDR, INCOMING_WORD_ADDR);
    wire                  wr_rst    = I_WR_STB && hit(I_ADDR, CHIP_RESET_PORT_ADDR);
    wire                  link_idle = (state_ff == ST_IDLE);

    // only a written 1 starts anything; a 0 is harmless, and starts while busy are dropped
    wire                  start_write = wr_ctrl && I_WDATA[WRITE_START_BUSY_BIT] && link_idle;
    // write start wins when both bits arrive together
    wire                  start_read  = wr_ctrl && I_WDATA[READ_START_BUSY_BIT]
                                        && !I_WDATA[WRITE_START_BUSY_BIT] && link_idle;
    wire                  receiving   = read_busy_ff && (bit_idx_ff >= RX_FIRST_IDX);
    wire                  last_bit    = (bit_idx_ff == LAST_BIT_IDX);
    wire [3:0]            bit_idx_inc = bit_idx_ff + 4'h1;

    // read data selection
    wire [DATA_W-1:0]     ctrl_view   = {14'h0000, write_busy_ff, read_busy_ff};
    wire [DATA_W-1:0]     div_view    = {8'h00, divisor_ff};
    wire [DATA_W-1:0]     in_view     = {incoming_byte_ff, fetch_target_ff};
    wire [DATA_W-1:0]     rst_view    = {15'h0000, chip_reset_level_ff};
    wire [DATA_W-1:0]     read_mux    =
        hit(I_ADDR, TRANSFER_CONTROL_ADDR)     ? ctrl_view :
        hit(I_ADDR, SERIAL_CLOCK_DIVISOR_ADDR) ? div_view :
        hit(I_ADDR, OUTGOING_WORD_ADDR)        ? outgoing_word_ff :
        hit(I_ADDR, INCOMING_WORD_ADDR)        ? in_view :
        hit(I_ADDR, CHIP_RESET_PORT_ADDR)      ? rst_view : WORD_RESET;

    // divider is live on the register; software keeps it steady during frames
    serial_clock_divider #(
        .DIV_W     (DIVISOR_W)
    ) u_divider (
        .i_clk     (I_CORE_CLK),
        .i_rst_n   (I_RST_N),
        .i_run     (state_ff == ST_SHIFT),
        .i_divisor (divisor_ff),
        .o_tick    (half_tick)
    );

    // three stage synchroniser; a level is accepted once stages two and three agree
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sdi_s1_ff   <= 1'b0;
            sdi_s2_ff   <= 1'b0;
            sdi_s3_ff   <= 1'b0;
            sdi_filt_ff <= 1'b0;
        end else begin
            sdi_s1_ff <= I_SERIAL_DATA_IN;
            sdi_s2_ff <= sdi_s1_ff;
            sdi_s3_ff <= sdi_s2_ff;
            if (sdi_s2_ff == sdi_s3_ff) begin
                sdi_filt_ff <= sdi_s3_ff;
            end
        end
    end

    // sequencer next state
    // each bit: clock low half, then high half; the bit advances on the falling tick.
    // sampling at the falling tick leaves the synchroniser a full serial clock period to settle,
    // which at divisors 0 and 1 is too short; slow rates are the safe choice for reads.
    always_comb begin
        nxt_state    = state_ff;
        nxt_tx_shift = tx_shift_ff;
        nxt_rx_shift = rx_shift_ff;
        nxt_bit_idx  = bit_idx_ff;
        nxt_sclk     = sclk_ff;
        nxt_sdo      = sdo_ff;
        nxt_sdo_oe   = sdo_oe_ff;
        frame_done   = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_sclk   = 1'b0;
                nxt_sdo_oe = 1'b0;
                if (start_write) begin
                    // whole outgoing word goes out, top bit first
                    nxt_tx_shift = outgoing_word_ff;
                    nxt_sdo      = outgoing_word_ff[DATA_W-1];
                    nxt_sdo_oe   = 1'b1;
                    nxt_bit_idx  = 4'h0;
                    nxt_state    = ST_SHIFT;
                end else if (start_read) begin
                    // target occupies the first eight bits of the frame
                    nxt_tx_shift = {fetch_target_ff, BYTE_RESET};
                    nxt_sdo      = fetch_target_ff[7];
                    nxt_sdo_oe   = 1'b1;
                    nxt_bit_idx  = 4'h0;
                    nxt_state    = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (half_tick && !sclk_ff) begin
                    // rising edge of the serial clock
                    nxt_sclk = 1'b1;
                end else if (half_tick) begin
                    // falling edge: take a returned bit, then move on
                    nxt_sclk = 1'b0;
                    if (receiving) begin
                        nxt_rx_shift = {rx_shift_ff[6:0], sdi_filt_ff};
                    end
                    if (last_bit) begin
                        // sixteen bits done; clock parks low and pin is released
                        frame_done = 1'b1;
                        nxt_sdo_oe = 1'b0;
                        nxt_state  = ST_IDLE;
                    end else begin
                        nxt_tx_shift = {tx_shift_ff[DATA_W-2:0], 1'b0};
                        nxt_sdo      = tx_shift_ff[DATA_W-2];
                        nxt_bit_idx  = bit_idx_inc;
                        // read frames let go of the pin after the target byte
                        nxt_sdo_oe   = !(read_busy_ff && (bit_idx_inc >= RX_FIRST_IDX));
                    end
                end
            end
            default: begin
                nxt_state  = ST_IDLE;
                nxt_sclk   = 1'b0;
                nxt_sdo_oe = 1'b0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_ff    <= ST_IDLE;
            tx_shift_ff <= WORD_RESET;
            rx_shift_ff <= BYTE_RESET;
            bit_idx_ff  <= 4'h0;
            sclk_ff     <= 1'b0;
            sdo_ff      <= 1'b0;
            sdo_oe_ff   <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            tx_shift_ff <= nxt_tx_shift;
            rx_shift_ff <= nxt_rx_shift;
            bit_idx_ff  <= nxt_bit_idx;
            sclk_ff     <= nxt_sclk;
            sdo_ff      <= nxt_sdo;
            sdo_oe_ff   <= nxt_sdo_oe;
        end
    end

    // busy flags: set by a start, cleared by the end of the frame
    // a start is refused while busy, so set and clear never meet
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            write_busy_ff <= TRANSFER_CONTROL_RESET[WRITE_START_BUSY_BIT];
            read_busy_ff  <= TRANSFER_CONTROL_RESET[READ_START_BUSY_BIT];
        end else begin
            write_busy_ff <= start_write || (write_busy_ff && !frame_done);
            read_busy_ff  <= start_read  || (read_busy_ff  && !frame_done);
        end
    end

    // divisor and reset port registers
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            divisor_ff          <= DIVISOR_RESET;
            chip_reset_level_ff <= CHIP_RESET_LEVEL_RESET;
        end else begin
            if (wr_div) begin
                divisor_ff <= I_WDATA[DIVISOR_W-1:0];
            end
            if (wr_rst) begin
                chip_reset_level_ff <= I_WDATA[CHIP_RESET_LEVEL_BIT];
            end
        end
    end

    // data registers; the hardware leaves their content undefined, we clear them anyway
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            outgoing_word_ff <= WORD_RESET;
            fetch_target_ff  <= BYTE_RESET;
        end else begin
            if (wr_out) begin
                outgoing_word_ff <= I_WDATA;
            end
            if (wr_in) begin
                // only the target half takes bus writes
                fetch_target_ff <= I_WDATA[7:0];
            end
        end
    end

    // received byte lands only at the end of a read frame
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            incoming_byte_ff <= BYTE_RESET;
        end else if (frame_done && read_busy_ff) begin
            incoming_byte_ff <= nxt_rx_shift;
        end
    end

    // read answer valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_ff <= WORD_RESET;
        end else begin
            rdata_ff <= I_RD_STB ? read_mux : WORD_RESET;
        end
    end

    // reset pin driven from the software port alone, never from the sequencer
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pin_reset_n_ff <= CHIP_RESET_LEVEL_RESET;
        end else begin
            pin_reset_n_ff <= chip_reset_level_ff;
        end
    end

    // outputs straight from flip-flops
    assign O_RDATA            = rdata_ff;
    assign O_SERIAL_CLOCK_OUT = sclk_ff;
    assign O_SERIAL_DATA_OUT  = sdo_ff;
    assign O_SERIAL_DATA_OE   = sdo_oe_ff;
    assign O_CHIP_RESET_PIN_N = pin_reset_n_ff;

    // helper counters watched only by the checks below
    logic [4:0] rise_cnt_ff;   // serial clock rises in the current frame
    logic [8:0] half_cnt_ff;   // cycles since the last clock change or start
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rise_cnt_ff <= 5'h00;
            half_cnt_ff <= 9'h000;
        end else begin
            rise_cnt_ff <= (start_write || start_read) ? 5'h00 :
                           (nxt_sclk && !sclk_ff) ? rise_cnt_ff + 5'h01 : rise_cnt_ff;
            half_cnt_ff <= (start_write || start_read || (nxt_sclk != sclk_ff)) ? 9'h000 :
                           half_cnt_ff + 9'h001;
        end
    end

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence frame_end_s;
        $fell(write_busy_ff || read_busy_ff);
    endsequence

    sequence idle_start_s;
        wr_ctrl && link_idle && (I_WDATA[WRITE_START_BUSY_BIT] || I_WDATA[READ_START_BUSY_BIT]);
    endsequence

    chk_frame_sixteen_clocks: assert property (frame_end_s |-> rise_cnt_ff == 5'h10)
        else $error("frame did not carry sixteen clocks");
    chk_half_period_len: assert property ($changed(sclk_ff) |-> {1'b0, divisor_ff} == $past(half_cnt_ff))
        else $error("serial clock half period wrong");
    chk_idle_quiet_pins: assert property (link_idle && $past(link_idle) |-> !sclk_ff && !sdo_oe_ff)
        else $error("link not quiet while idle");
    chk_write_start_busy: assert property (start_write |=> write_busy_ff && !read_busy_ff)
        else $error("write start did not set busy");
    chk_zero_no_start: assert property (wr_ctrl && link_idle && I_WDATA[1:0] == 2'b00
                                        |=> !write_busy_ff && !read_busy_ff)
        else $error("zero write started a frame");
    chk_ctrl_reserved_zero: assert property (I_RD_STB && hit(I_ADDR, TRANSFER_CONTROL_ADDR)
                                             |=> O_RDATA[15:2] == 14'h0000)
        else $error("control reserved bits not zero");
    chk_div_upper_zero: assert property (I_RD_STB && hit(I_ADDR, SERIAL_CLOCK_DIVISOR_ADDR)
                                         |=> O_RDATA[15:8] == 8'h00)
        else $error("divisor upper byte not zero");
    chk_write_load_shift: assert property (idle_start_s ##0 I_WDATA[WRITE_START_BUSY_BIT]
                                           |=> tx_shift_ff == $past(outgoing_word_ff) ##0 sdo_oe_ff)
        else $error("outgoing word not loaded");
    chk_read_releases_pin: assert property (read_busy_ff && state_ff == ST_SHIFT && receiving |-> !sdo_oe_ff)
        else $error("pin driven during receive half");
    chk_rx_byte_readonly: assert property (wr_in && !frame_done |=> $stable(incoming_byte_ff))
        else $error("bus write changed received byte");
    chk_reset_pin_follow: assert property (wr_rst |-> ##2 O_CHIP_RESET_PIN_N == $past(I_WDATA[0], 2))
        else $error("reset pin not following port");

endmodule
`default_nettype wire

// File: src/clock_chip_link_pkg.sv
// constants, field positions and types shared by the clock chip link controller
package clock_chip_link_pkg;

    // bus geometry
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;

    // register offsets on the plain register port
    localparam logic [ADDR_W-1:0] TRANSFER_CONTROL_ADDR     = 24'h21C000;
    localparam logic [ADDR_W-1:0] SERIAL_CLOCK_DIVISOR_ADDR = 24'h21C002;
    localparam logic [ADDR_W-1:0] OUTGOING_WORD_ADDR        = 24'h21C004;
    localparam logic [ADDR_W-1:0] INCOMING_WORD_ADDR        = 24'h21C006;
    localparam logic [ADDR_W-1:0] CHIP_RESET_PORT_ADDR      = 24'h21C008;

    // field positions (bit 0 is the least significant bit)
    localparam int WRITE_START_BUSY_BIT = 1;
    localparam int READ_START_BUSY_BIT  = 0;
    localparam int CHIP_RESET_LEVEL_BIT = 0;
    localparam int HIGH_BYTE_LSB        = 8;
    localparam int DIVISOR_W            = 8;

    // reset values
    localparam logic [DATA_W-1:0]    TRANSFER_CONTROL_RESET = 16'h0000;
    localparam logic [DIVISOR_W-1:0] DIVISOR_RESET          = 8'h00;
    localparam logic [DATA_W-1:0]    WORD_RESET             = 16'h0000;
    localparam logic [7:0]           BYTE_RESET             = 8'h00;
    localparam logic                 CHIP_RESET_LEVEL_RESET = 1'b0;

    // frame layout
    localparam int         FRAME_BITS    = 16;
    localparam logic [3:0] LAST_BIT_IDX  = 4'hF;
    localparam logic [3:0] RX_FIRST_IDX  = 4'h8;

    // timing figures
    localparam int CORE_CLK_PERIOD_NS = 40;
    localparam int CORE_CLK_HZ        = 1_000_000_000 / CORE_CLK_PERIOD_NS;
    localparam int LINE_RATE_MIN_BPS  = 105468;
    localparam int LINE_RATE_MAX_BPS  = 27000000;

    // link sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } link_state_t;

endpackage

// File: src/serial_clock_divider.sv
// tick generator that paces each half period of the serial clock
`timescale 1ns/1ps
`default_nettype none
module serial_clock_divider #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // control
    input  wire logic             i_run,
    input  wire logic [DIV_W-1:0] i_divisor,
    // pacing
    output logic                  o_tick
);

    logic [DIV_W-1:0] count_ff;     // cycles spent in the current half period
    logic [DIV_W-1:0] nxt_count;    // next count value
    logic             nxt_tick;     // half period ends this cycle

    // a tick every divisor+1 cycles; two ticks make one serial clock period
    assign nxt_tick  = i_run && (count_ff == i_divisor);
    assign nxt_count = (!i_run || nxt_tick) ? '0 : count_ff + 1'b1;

    // counter held at zero while idle so every frame starts phase aligned
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // combinational tick, consumed by the sequencer on the same edge
    assign o_tick = nxt_tick;

endmodule
`default_nettype wire

// File: tb/clock_chip_model.sv
// behavioural model of the external clock chip on the three-wire link
`timescale 1ns/1ps
`default_nettype none
module clock_chip_model (
    // link pins and reply byte
    input  wire logic       i_sclk,
    input  wire logic       i_rst_n,
    input  wire logic       i_sdio,
    input  wire logic [7:0] i_reply,
    // line level and frame report
    output logic            o_level,
    output logic [15:0]     o_word,
    output logic [31:0]     o_span,
    output logic [7:0]      o_frames
);
    int   cnt;   // rising edges seen in this frame
    time  t0;    // first rising edge of the frame
    logic rd;    // frame asks for a byte back
    logic drive; // chip owns the data line
    // sample the line on each rising edge, sixteen to a frame
    always @(posedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt = 0;
            rd = 1'b0;
            o_frames = 8'h00;
        end else begin
            if (cnt == 0)
                t0 = $time;
            o_word = {o_word[14:0], i_sdio};
            cnt++;
            if (cnt == 8)
                rd = i_sdio; // odd target wants a reply
            if (cnt == 16) begin
                o_span = 32'($time - t0);
                cnt = 0;
                o_frames++;
            end
        end
    end
    // reply after the target byte, top bit first; release at frame end
    always @(negedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drive = 1'b0;
            o_level = 1'b1;
        end else if (rd && cnt >= 8) begin
            drive = 1'b1;
            o_level = i_reply[15 - cnt];
        end else if (drive) begin
            drive = 1'b0;
            o_level = ~o_level; // released line shows no stale bit
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the clock chip link controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import clock_chip_link_pkg::*;
    logic              clk = 1'b0;   // core clock
    logic              rst_n = 1'b1; // reset, active low
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              rd_seen = 1'b0; // read strobe taken at last edge
    logic [DATA_W-1:0] rdata;
    logic              sclk, sdo, oe, rstpin, level;
    logic [15:0]       word, w, st;
    logic [31:0]       span, sp;
    logic [7:0]        frames, b, t, last_rx;
    logic [7:0]        reply = 8'h00; // byte the chip hands back
    logic [DATA_W-1:0] rq[$];         // expected read data
    logic [47:0]       fq[$];         // expected frames, span over word
    int                num_errors = 0;
    int                comparisons = 0;
    int                cycles = 0;
    int                div;
    wire logic         sdin = oe ? sdo : level; // controller or chip drives
    clock_chip_link_controller dut_u (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR_STB(wr), .I_RD_STB(rd), .O_RDATA(rdata), .O_SERIAL_CLOCK_OUT(sclk),
        .O_SERIAL_DATA_OUT(sdo), .O_SERIAL_DATA_OE(oe), .I_SERIAL_DATA_IN(sdin),
        .O_CHIP_RESET_PIN_N(rstpin));
    clock_chip_model chip_u (.i_sclk(sclk), .i_rst_n(rst_n), .i_sdio(sdin), .i_reply(reply),
        .o_level(level), .o_word(word), .o_span(span), .o_frames(frames));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic cmp_reg(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_frame(input logic [47:0] g, input logic [47:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // note the expectation, then strobe; the watcher compares
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        rq.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic close_out();
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // read data stand only in the cycle after the strobe; also the hang limit
    always @(posedge clk) begin
        if (rd_seen)
            cmp_reg(rdata, rq.pop_front());
        rd_seen <= rd;
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            close_out();
        end
    end
    always @(frames) begin
        if (rst_n === 1'b1)
            cmp_frame({span, word}, fq.pop_front());
    end
    initial begin
        void'($urandom(32'hF303));
        #1 rst_n = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        last_rx = 8'h00;
        // reset values, then the first unmapped place
        for (int i = 0; i < 6; i++)
            rd_chk(TRANSFER_CONTROL_ADDR + 24'(2 * i), 16'h0000);
        div = 3 + int'($urandom % 4);
        sp = 32'(30 * (div + 1) * CORE_CLK_PERIOD_NS);
        wr_reg(SERIAL_CLOCK_DIVISOR_ADDR, 16'hFF00 | 16'(div));
        rd_chk(SERIAL_CLOCK_DIVISOR_ADDR, 16'(div));
        wr_reg(TRANSFER_CONTROL_ADDR, 16'hFFFC); // zeros to both start bits
        rd_chk(TRANSFER_CONTROL_ADDR, 16'h0000);
        // seven writes, then seven reads, one per time field
        for (int i = 0; i < 14; i++) begin
            t = 8'h80 + 8'(2 * (i % 7)) + 8'(i / 7);
            b = 8'($urandom);
            st = (i < 7) ? 16'h0002 : 16'h0001;
            w = (i < 7) ? {b, t} : {8'($urandom), t};
            wr_reg((i < 7) ? OUTGOING_WORD_ADDR : INCOMING_WORD_ADDR, w);
            rd_chk((i < 7) ? OUTGOING_WORD_ADDR : INCOMING_WORD_ADDR, (i < 7) ? w : {last_rx, t});
            reply <= b;
            fq.push_back({sp, (i < 7) ? w : {t, b}});
            // one write frame starts with both bits set: write must win
            wr_reg(TRANSFER_CONTROL_ADDR, (i == 3) ? 16'h0003 : st);
            rd_chk(TRANSFER_CONTROL_ADDR, st);
            wr_reg(TRANSFER_CONTROL_ADDR, ~st & 16'h0003); // start while busy is dropped
            rd_chk(TRANSFER_CONTROL_ADDR, st);
            repeat (32 * (div + 1)) @(posedge clk);
            rd_chk(TRANSFER_CONTROL_ADDR, 16'h0000);
            @(negedge clk);
            cmp_reg({14'h0000, sclk, oe}, 16'h0000);
            if (i >= 7)
                rd_chk(INCOMING_WORD_ADDR, {b, t});
            if (i >= 7)
                last_rx = b;
        end
        // every start taken must have produced exactly one frame
        cmp_reg({8'h00, frames}, 16'h000E);
        cmp_reg({15'h0000, rstpin}, 16'h0000);
        for (int j = 1; j >= 0; j--) begin
            wr_reg(CHIP_RESET_PORT_ADDR, 16'hFFFE | 16'(j));
            rd_chk(CHIP_RESET_PORT_ADDR, 16'(j));
            @(negedge clk);
            cmp_reg({15'h0000, rstpin}, 16'(j));
        end
        repeat (2) @(posedge clk);
        close_out();
    end
endmodule
`default_nettype wire
